//--- hdl/fault_event_record_builder.sv
// Fault event record builder: range check, merging, queue gating and APB registers.
//
// Notes on behaviour
// - Each record is 32 bytes, byte n holding record bits 8n+7 down to 8n.
// - A record goes to the queue of the causing requester's security state.
// - Direction bit is 0 for write, 1 for read.
// - Privilege bit is the overridden value, 1 meaning privileged.
// - Instruction bit is the overridden value, 1 meaning instruction fetch.
// - Incoming address is stored whole, top byte untouched.
// - Substream valid flag marks whether the substream field holds a value.
// - Class field codes context fetch, walk fetch or input address.
// - Nonsecure IPA bit is zero except stage 2 faults on the secure queue.
// - Fetch events carry the structure fetch address as computed.
// - Undefined record bits are zero.
// - Without merge enable only pre-entry events may merge.
// - Merging needs identical records close together in time.
// - Stalled events are never merged.
// - Records are merged only inside a short window after a written one.
// - The four pre-entry events may merge regardless of merge enable.
// - Unsupported transaction is event 0x01 with incoming privilege and instruction bits.
// - Unsupported transaction is recorded even with translation disabled.
// - Bad requester event 0x02 only when recording is enabled; id range checked.
// - Two-level tables also check descriptor span and low split bits.
// - Each security state checks its own table size and uses its own queue.
// - Records are written only to writable queues; stalled events wait.
`timescale 1ns/1ns
module fault_event_record_builder
    import event_record_pkg::*;
#(
    parameter int ID_W  = 32,
    parameter int SUB_W = 20
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              evValid,
    output logic                   evReady,
    input  wire logic [7:0]        evNum,
    input  wire logic              evSecure,
    input  wire logic [ID_W-1:0]   evRequesterIdentifier,
    input  wire logic              evSubstreamValid,
    input  wire logic [SUB_W-1:0]  evSubRequesterIdentifier,
    input  wire logic              evAccessDirection,
    input  wire logic              evRawPrivilege,
    input  wire logic              evRawInstr,
    input  wire logic              evPrivilegeFlag,
    input  wire logic              evInstrOrDataFlag,
    input  wire logic [63:0]       evIncomingAddress,
    input  wire logic              evFaultStage,
    input  wire logic [1:0]        evFaultClass,
    input  wire logic              evStage1Ns,
    input  wire logic              evStage1Bypass,
    input  wire logic              evEntryNsConfig,
    input  wire logic              evMergeEnable,
    input  wire logic              evHasStall,
    input  wire logic              evStall,
    input  wire logic [31:0]       evReason,
    input  wire logic              evHasFetch,
    input  wire logic [63:0]       evFetchAddress,
    input  wire logic [4:0]        evLevel1Span,
    input  wire logic [1:0]        queueFull,
    input  wire logic [1:0]        queueAbort,
    output logic                   recValid,
    output logic                   recSecure,
    output logic [REC_BITS-1:0]    record
);

    // ========================================
    // Parameter checks
    if (ID_W < 1 || ID_W > 32) begin : g_bad_id
        $error("ID_W must lie between 1 and 32.");
    end
    if (SUB_W < 1 || SUB_W > REC_SUB_BITS) begin : g_bad_sub
        $error("SUB_W must lie between 1 and 20.");
    end

    // ========================================
    // Requester range check
    function automatic logic rangeFault(input logic [31:0] id, input logic [5:0] logSize,
                                        input logic twoLevel, input logic [4:0] split,
                                        input logic [4:0] span);
        logic [31:0] lowMask;
        logic        fault;
        fault   = (logSize < 6'd32) && ((id >> logSize) != 32'h0);
        lowMask = (32'h1 << split) - 32'h1;
        if (twoLevel) begin
            if (span == 5'h0 || span >= SPAN_RESERVED_MIN) begin
                fault = 1'b1;
            end else if ({1'b0, span} > ({1'b0, split} + 6'd1)) begin
                fault = 1'b1;
            end else if ((id & lowMask) >= (32'h1 << (span - 5'h1))) begin
                fault = 1'b1;
            end
        end
        return fault;
    endfunction

    // ========================================
    // Register state
    logic [31:0] ctrl;
    logic [31:0] nsTable;
    logic [31:0] sTable;
    logic [15:0] writtenCnt;
    logic [15:0] mergedCnt;
    logic [15:0] discardCnt;
    logic [31:0] next_ctrl;
    logic [31:0] next_nsTable;
    logic [31:0] next_sTable;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;

    // ========================================
    // Event state
    localparam int TW = $clog2(MERGE_WINDOW_CYC + 1);
    localparam logic [TW-1:0] WINDOW_LOAD = TW'(MERGE_WINDOW_CYC);

    hold_state_t         state;
    hold_state_t         next_state;
    logic [REC_BITS-1:0] heldRec;
    logic                heldSec;
    logic [REC_BITS-1:0] lastRec;
    logic                lastSec;
    logic [TW-1:0]       timer;
    logic [REC_BITS-1:0] next_heldRec;
    logic                next_heldSec;
    logic [REC_BITS-1:0] next_lastRec;
    logic                next_lastSec;
    logic [TW-1:0]       next_timer;
    logic                next_recValid;
    logic                next_recSecure;
    logic [REC_BITS-1:0] next_record;
    logic                next_evReady;
    logic [15:0]         next_writtenCnt;
    logic [15:0]         next_mergedCnt;
    logic [15:0]         next_discardCnt;

    // ========================================
    // Event decode
    logic       accept;
    logic       isUnsupported;
    logic       badId;
    logic [7:0] effNum;
    logic       preEntry;
    logic       keep;
    logic       mergeHit;
    logic [1:0] writableVec;
    logic       writableNow;
    logic [5:0] logSize;
    logic [4:0] split;
    logic       twoLevel;
    logic       sec;

    event_fields_if fields ();

    assign sec           = evSecure;
    assign logSize       = sec ? sTable[TBL_LOG_LSB +: 6] : nsTable[TBL_LOG_LSB +: 6];
    assign split         = sec ? sTable[TBL_SPLIT_LSB +: 5] : nsTable[TBL_SPLIT_LSB +: 5];
    assign twoLevel      = sec ? sTable[TBL_FMT_BIT] : nsTable[TBL_FMT_BIT];
    assign accept        = evValid && evReady;
    assign isUnsupported = (evNum == EV_UNSUPPORTED);
    assign badId         = rangeFault(32'(evRequesterIdentifier), logSize, twoLevel, split,
                                      evLevel1Span);
    assign effNum        = (badId && !isUnsupported) ? EV_BAD_REQUESTER : evNum;
    assign preEntry      = (effNum >= EV_UNSUPPORTED) && (effNum <= EV_BAD_ENTRY);
    assign writableVec   = ctrl[CTRL_QUEUE_LSB +: 2] & ~queueFull & ~queueAbort;
    assign writableNow   = writableVec[sec];

    always_comb begin
        if (isUnsupported) begin
            keep = 1'b1;
        end else if (effNum == EV_BAD_REQUESTER) begin
            keep = ctrl[CTRL_RECINV_LSB + 32'(sec)] && ctrl[CTRL_GLOBAL_LSB + 32'(sec)];
        end else begin
            keep = ctrl[CTRL_GLOBAL_LSB + 32'(sec)];
        end
    end

    // ========================================
    // Field selection
    assign fields.num             = effNum;
    assign fields.requester       = 32'(evRequesterIdentifier);
    assign fields.subValid        = evSubstreamValid;
    assign fields.sub             = REC_SUB_BITS'(evSubRequesterIdentifier);
    assign fields.accessDirection = evAccessDirection;
    assign fields.privilegeFlag   = isUnsupported ? evRawPrivilege : evPrivilegeFlag;
    assign fields.instrOrDataFlag = isUnsupported ? evRawInstr : evInstrOrDataFlag;
    assign fields.incomingAddress = evIncomingAddress;
    assign fields.faultStage      = evFaultStage;
    assign fields.faultClass      = evFaultClass;
    assign fields.nonsecureIpaBit = sec && evFaultStage &&
                                    (evStage1Bypass ? evEntryNsConfig : evStage1Ns);
    assign fields.reason          = evReason;
    assign fields.hasFetch        = evHasFetch;
    assign fields.fetchAddress    = evFetchAddress;

    event_record_packer u_packer (
        .f (fields.packer)
    );

    assign mergeHit = (evMergeEnable || preEntry) && !(evHasStall && evStall) &&
                      (timer != '0) && (fields.record == lastRec) && (sec == lastSec);

    // ========================================
    // Event next state
    always_comb begin
        next_state      = state;
        next_heldRec    = heldRec;
        next_heldSec    = heldSec;
        next_lastRec    = lastRec;
        next_lastSec    = lastSec;
        next_timer      = (timer != '0) ? timer - TW'(1) : timer;
        next_recValid   = 1'b0;
        next_recSecure  = recSecure;
        next_record     = record;
        next_writtenCnt = writtenCnt;
        next_mergedCnt  = mergedCnt;
        next_discardCnt = discardCnt;
        case (state)
            ST_IDLE: begin
                if (accept && keep) begin
                    if (mergeHit) begin
                        next_mergedCnt = mergedCnt + 16'h1;
                    end else if (writableNow) begin
                        next_recValid   = 1'b1;
                        next_recSecure  = sec;
                        next_record     = fields.record;
                        next_lastRec    = fields.record;
                        next_lastSec    = sec;
                        next_timer      = WINDOW_LOAD;
                        next_writtenCnt = writtenCnt + 16'h1;
                    end else if (evHasStall && evStall) begin
                        next_state   = ST_HOLD;
                        next_heldRec = fields.record;
                        next_heldSec = sec;
                    end else begin
                        next_discardCnt = discardCnt + 16'h1;
                    end
                end
            end
            ST_HOLD: begin
                if (writableVec[heldSec]) begin
                    next_state      = ST_IDLE;
                    next_recValid   = 1'b1;
                    next_recSecure  = heldSec;
                    next_record     = heldRec;
                    next_lastRec    = heldRec;
                    next_lastSec    = heldSec;
                    next_timer      = WINDOW_LOAD;
                    next_writtenCnt = writtenCnt + 16'h1;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        next_evReady = (next_state == ST_IDLE);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state      <= ST_IDLE;
            heldRec    <= '0;
            heldSec    <= 1'b0;
            lastRec    <= '0;
            lastSec    <= 1'b0;
            timer      <= '0;
            recValid   <= 1'b0;
            recSecure  <= 1'b0;
            record     <= '0;
            evReady    <= 1'b0;
            writtenCnt <= 16'h0;
            mergedCnt  <= 16'h0;
            discardCnt <= 16'h0;
        end else begin
            state      <= next_state;
            heldRec    <= next_heldRec;
            heldSec    <= next_heldSec;
            lastRec    <= next_lastRec;
            lastSec    <= next_lastSec;
            timer      <= next_timer;
            recValid   <= next_recValid;
            recSecure  <= next_recSecure;
            record     <= next_record;
            evReady    <= next_evReady;
            writtenCnt <= next_writtenCnt;
            mergedCnt  <= next_mergedCnt;
            discardCnt <= next_discardCnt;
        end
    end

    // ========================================
    // APB slave
    logic apbWrite;

    assign apbWrite = psel && penable && pready && pwrite;

    always_comb begin
        next_ctrl    = ctrl;
        next_nsTable = nsTable;
        next_sTable  = sTable;
        next_pready  = psel && penable && !pready;
        next_prdata  = 32'h0;
        next_pslverr = 1'b0;
        if (paddr == OFF_CTRL) begin
            next_prdata = ctrl;
        end else if (paddr == OFF_NS_TABLE) begin
            next_prdata = nsTable;
        end else if (paddr == OFF_S_TABLE) begin
            next_prdata = sTable;
        end else if (paddr == OFF_COUNTS) begin
            next_prdata = {mergedCnt, writtenCnt};
        end else if (paddr == OFF_DISCARDS) begin
            next_prdata = {16'h0, discardCnt};
        end else begin
            next_pslverr = 1'b1;
        end
        if (!next_pready || !pwrite) begin
            next_pslverr = next_pslverr && next_pready;
        end else begin
            next_prdata = 32'h0;
        end
        if (apbWrite) begin
            if (paddr == OFF_CTRL) begin
                next_ctrl = pwdata & CTRL_MASK;
            end else if (paddr == OFF_NS_TABLE) begin
                next_nsTable = pwdata & TABLE_MASK;
            end else if (paddr == OFF_S_TABLE) begin
                next_sTable = pwdata & TABLE_MASK;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl    <= CTRL_RESET;
            nsTable <= TABLE_RESET;
            sTable  <= TABLE_RESET;
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            ctrl    <= next_ctrl;
            nsTable <= next_nsTable;
            sTable  <= next_sTable;
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ========================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_queue_writable;
        recValid |-> (recSecure ? $past(writableVec[1]) : $past(writableVec[0]));
    endproperty
    a_queue_writable: assert property (p_queue_writable) else $error("Record to closed queue.");

    property p_reserved_zero;
        recValid |-> ((record & ~REC_DEFINED_MASK) == '0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bit set.");

    property p_no_stall_merge;
        accept && evHasStall && evStall |=> $stable(mergedCnt);
    endproperty
    a_no_stall_merge: assert property (p_no_stall_merge) else $error("Stalled merge.");

    property p_merge_enable;
        accept && !evMergeEnable && !preEntry |=> $stable(mergedCnt);
    endproperty
    a_merge_enable: assert property (p_merge_enable) else $error("Merge while disabled.");

    property p_recinv_gate;
        accept && effNum == EV_BAD_REQUESTER && !ctrl[CTRL_RECINV_LSB + 32'(sec)] |=> !recValid;
    endproperty
    a_recinv_gate: assert property (p_recinv_gate) else $error("Bad requester recorded.");

    property p_nonsecure_ipa_bit_zero;
        recValid && !(recSecure && record[REC_STAGE_BIT]) |-> !record[REC_NONSECURE_IPA_BIT_BIT];
    endproperty
    a_nonsecure_ipa_bit_zero: assert property (p_nonsecure_ipa_bit_zero) else $error("Nonsecure IPA bit set.");

    sequence s_written;
        accept && keep && !mergeHit && writableNow;
    endsequence

    property p_address_kept;
        logic [63:0] a;
        (s_written, a = evIncomingAddress) |=> recValid && record[REC_ADDR_LSB +: 64] == a;
    endproperty
    a_address_kept: assert property (p_address_kept) else $error("Address altered.");

    property p_uut_recorded;
        s_written ##0 isUnsupported |=> recValid && record[7:0] == EV_UNSUPPORTED;
    endproperty
    a_uut_recorded: assert property (p_uut_recorded) else $error("Unsupported event lost.");

    property p_class_legal;
        recValid |-> record[REC_CLASS_LSB +: 2] != CLASS_RESERVED;
    endproperty
    a_class_legal: assert property (p_class_legal) else $error("Reserved class code.");

    property p_merge_window;
        !$stable(mergedCnt) |-> $past(timer) != '0;
    endproperty
    a_merge_window: assert property (p_merge_window) else $error("Merge outside window.");

endmodule

//--- hdl/event_record_pkg.sv
// Constants, record layout and register map of the fault event record builder.
package event_record_pkg;

    // ========================================
    // Record layout
    localparam int REC_BITS       = 256;
    localparam int REC_NUM_LSB    = 0;
    localparam int REC_SSV_BIT    = 11;
    localparam int REC_SUB_LSB    = 12;
    localparam int REC_SUB_BITS   = 20;
    localparam int REC_ID_LSB     = 32;
    localparam int REC_REASON_LSB = 64;
    localparam int REC_NONSECURE_IPA_BIT_BIT  = 96;
    localparam int REC_DIR_BIT    = 99;
    localparam int REC_INSTR_BIT  = 100;
    localparam int REC_PRIV_BIT   = 101;
    localparam int REC_STAGE_BIT  = 103;
    localparam int REC_CLASS_LSB  = 104;
    localparam int REC_ADDR_LSB   = 128;
    localparam int REC_FETCH_LSB  = 192;
    localparam logic [255:0] REC_DEFINED_MASK = {128'hffffffffffffffffffffffffffffffff,
        32'h000003b9, 64'hffffffffffffffff, 32'hfffff8ff};

    // ========================================
    // Event numbers and fault classes
    localparam logic [7:0] EV_UNSUPPORTED   = 8'h01;
    localparam logic [7:0] EV_BAD_REQUESTER = 8'h02;
    localparam logic [7:0] EV_ENTRY_FETCH   = 8'h03;
    localparam logic [7:0] EV_BAD_ENTRY     = 8'h04;
    localparam logic [1:0] CLASS_CONTEXT    = 2'h0;
    localparam logic [1:0] CLASS_WALK       = 2'h1;
    localparam logic [1:0] CLASS_INPUT      = 2'h2;
    localparam logic [1:0] CLASS_RESERVED   = 2'h3;
    localparam logic [4:0] SPAN_RESERVED_MIN = 5'h0c;

    // ========================================
    // Register map
    localparam logic [11:0] OFF_CTRL     = 12'h000;
    localparam logic [11:0] OFF_NS_TABLE = 12'h004;
    localparam logic [11:0] OFF_S_TABLE  = 12'h008;
    localparam logic [11:0] OFF_COUNTS   = 12'h00c;
    localparam logic [11:0] OFF_DISCARDS = 12'h010;
    localparam int CTRL_GLOBAL_LSB  = 0;
    localparam int CTRL_QUEUE_LSB   = 2;
    localparam int CTRL_RECINV_LSB  = 4;
    localparam logic [31:0] CTRL_MASK  = 32'h0000003f;
    localparam logic [31:0] TABLE_MASK = 32'h000107ff;
    localparam logic [31:0] CTRL_RESET  = 32'h00000000;
    localparam logic [31:0] TABLE_RESET = 32'h00000000;
    localparam int TBL_LOG_LSB   = 0;
    localparam int TBL_SPLIT_LSB = 6;
    localparam int TBL_FMT_BIT   = 16;

    // ========================================
    // Timing
    localparam int CLK_PERIOD_NS    = 100;
    localparam int MERGE_WINDOW_NS  = 2000;
    localparam int MERGE_WINDOW_CYC = MERGE_WINDOW_NS / CLK_PERIOD_NS;

    typedef enum logic {ST_IDLE, ST_HOLD} hold_state_t;

endpackage

//--- hdl/event_fields_if.sv
// Field bundle between the record builder and the record packer.
`timescale 1ns/1ns
interface event_fields_if;
    logic [7:0]   num;
    logic [31:0]  requester;
    logic         subValid;
    logic [19:0]  sub;
    logic         accessDirection;
    logic         privilegeFlag;
    logic         instrOrDataFlag;
    logic [63:0]  incomingAddress;
    logic         faultStage;
    logic [1:0]   faultClass;
    logic         nonsecureIpaBit;
    logic [31:0]  reason;
    logic         hasFetch;
    logic [63:0]  fetchAddress;
    logic [255:0] record;

    modport builder (output num, requester, subValid, sub, accessDirection, privilegeFlag,
                     instrOrDataFlag, incomingAddress, faultStage, faultClass, nonsecureIpaBit,
                     reason, hasFetch, fetchAddress, input record);
    modport packer  (input num, requester, subValid, sub, accessDirection, privilegeFlag,
                     instrOrDataFlag, incomingAddress, faultStage, faultClass, nonsecureIpaBit,
                     reason, hasFetch, fetchAddress, output record);
endinterface

//--- hdl/event_record_packer.sv
// Places the event fields at their fixed bit positions of a 32-byte record.
`timescale 1ns/1ns
module event_record_packer
    import event_record_pkg::*;
(
    event_fields_if.packer f
);

    // ========================================
    // Packing
    always_comb begin
        f.record = '0;
        f.record[REC_NUM_LSB +: 8] = f.num;
        f.record[REC_SSV_BIT] = f.subValid;
        if (f.subValid) begin
            f.record[REC_SUB_LSB +: REC_SUB_BITS] = f.sub;
        end
        f.record[REC_ID_LSB +: 32] = f.requester;
        f.record[REC_REASON_LSB +: 32] = f.reason;
        f.record[REC_NONSECURE_IPA_BIT_BIT] = f.nonsecureIpaBit;
        f.record[REC_DIR_BIT] = f.accessDirection;
        f.record[REC_INSTR_BIT] = f.instrOrDataFlag;
        f.record[REC_PRIV_BIT] = f.privilegeFlag;
        f.record[REC_STAGE_BIT] = f.faultStage;
        f.record[REC_CLASS_LSB +: 2] = f.faultClass;
        f.record[REC_ADDR_LSB +: 64] = f.incomingAddress;
        if (f.hasFetch) begin
            f.record[REC_FETCH_LSB +: 64] = f.fetchAddress;
        end
    end

endmodule

//--- tb/event_source.sv
// Upstream client model that offers events.
`timescale 1ns/1ns
module event_source (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic kick,
    input  wire logic evReady,
    output logic      evValid
);
    always @(posedge clk or posedge rst) evValid <= rst ? 1'b0 : kick | evValid & ~evReady;
endmodule

//--- tb/testbench.sv
// Self-checking bench for the fault event record builder.
`timescale 1ns/1ns
module testbench import event_record_pkg::*; ;
    logic         clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, kick = 0, st = 0;
    logic         evSecure = 0, evFaultStage = 0, evMergeEnable = 0, evValid, evReady;
    logic         pready, pslverr, recValid, recSecure;
    logic [1:0]   queueFull = 0;
    logic [7:0]   evNum = 0;
    logic [11:0]  paddr = 0;
    logic [31:0]  pwdata = 0, prdata, evRequesterIdentifier = 0, r = 0, b = 0;
    logic [63:0]  a = 0;
    logic [255:0] record;
    logic [256:0] expq[$];
    int           seed = 32'he75a5f71, err_count = 0, num_checks = 0;
    fault_event_record_builder DUT (.*, .evSubstreamValid(b[5]), .evSubRequesterIdentifier(b[28:9]),
        .evAccessDirection(b[0]), .evRawPrivilege(b[3]), .evRawInstr(b[4]), .evReason(r),
        .evPrivilegeFlag(b[1]), .evInstrOrDataFlag(b[2]), .evIncomingAddress(a),
        .evFaultClass(b[30:29]), .evStage1Ns(b[6]), .evStage1Bypass(b[7]), .evStall(st),
        .evEntryNsConfig(b[8]), .evHasStall(st), .evHasFetch(b[31]), .evFetchAddress(a),
        .evLevel1Span(5'h0), .queueAbort(2'h0));
    event_source SRC (.*);
    initial forever #50 clk = ~clk;
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp(input string s, input logic [256:0] x, y);
        num_checks++;
        if (y !== x) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", s, x, y);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] ad, input logic [32:0] d, x);
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, d[31:0]};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        {psel, penable} <= 2'b0;
        cmp("apb", x, {pslverr, prdata});
    endtask
    task automatic ev(input logic [7:0] n, input logic [31:0] id, input logic [4:0] f);
        logic [63:0] na;
        logic [31:0] nr, nb;
        {na, nr, nb} = f[1] ? {a, r, b} :
            {$random(seed), $random(seed), $random(seed), $random(seed)};
        if (nb[30:29] == 2'h3) nb[30] = 1'b0;
        if (f[0]) expq.push_back({f[4], nb[31] ? na : 64'h0, na, 22'h0, nb[30:29], f[3], 1'b0,
            n == EV_UNSUPPORTED ? {nb[3], nb[4]} : {nb[1], nb[2]}, nb[0], 2'h0,
            f[4] & f[3] & (nb[7] ? nb[8] : nb[6]), nr, id, nb[5] ? nb[28:9] : 20'h0, nb[5],
            3'h0, id > 15 && !f[4] && n != EV_UNSUPPORTED ? EV_BAD_REQUESTER : n});
        @(posedge clk);
        {a, r, b, evNum, evRequesterIdentifier} <= {na, nr, nb, n, id};
        {evSecure, evFaultStage, evMergeEnable, kick} <= {f[4:2], 1'b1};
        @(posedge clk);
        kick <= 1'b0;
        do @(posedge clk); while (evValid === 1'b1);
        $display("done %h", n);
    endtask
    always @(posedge clk) if (recValid === 1'b1)
        cmp("record", expq.size() > 0 ? expq.pop_front() : 'x, {recSecure, record});
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        apb(1'b1, OFF_CTRL, 33'h3f, 33'h0);
        apb(1'b1, OFF_NS_TABLE, 33'h4, 33'h0);
        apb(1'b1, OFF_S_TABLE, 33'h20, 33'h0);
        apb(1'b0, OFF_CTRL, 33'h0, 33'h3f);
        apb(1'b0, 12'h020, 33'h0, 33'h100000000);
        ev(8'h10, 3, 5'b00101);
        ev(8'h10, 3, 5'b00110);
        ev(8'h10, 3, 5'b00011);
        ev(8'h03, 4, 5'b00001);
        ev(8'h03, 4, 5'b00010);
        ev(8'h10, 20, 5'b00101);
        ev(8'h10, 20, 5'b11101);
        queueFull <= 2'h1;
        ev(8'h10, 5, 5'b00100);
        st <= 1'b1;
        ev(8'h10, 5, 5'b00101);
        queueFull <= 2'h0;
        ev(8'h10, 5, 5'b00111);
        st <= 1'b0;
        queueFull <= 2'h0;
        apb(1'b1, OFF_CTRL, 33'h3e, 33'h0);
        ev(8'h01, 6, 5'b00101);
        repeat (25) @(posedge clk);
        ev(8'h01, 6, 5'b00111);
        repeat (5) @(posedge clk);
        cmp("pending", 257'h0, 257'(expq.size()));
        wrap_up();
    end
    initial begin
        #200000 err_count++;
        wrap_up();
    end
endmodule
